// ===== design/led_startup_pkg.sv
package led_startup_pkg;
    // channel count and register geometry
    localparam int unsigned NCH = 12;
    localparam int unsigned STEP_W = 6;
    localparam int unsigned DUTY_W = 12;
    // register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CONFIG = 12'h008;
    localparam logic [11:0] ADDR_ENABLE = 12'h00c;
    localparam logic [11:0] ADDR_FAILSAFE = 12'h010;
    localparam logic [11:0] ADDR_STEP_BASE = 12'h040;
    localparam logic [11:0] ADDR_DUTY_BASE = 12'h080;
    // command bits in the control word (write-only, self clearing)
    localparam int unsigned CTRL_RELOAD_BIT = 0;
    localparam int unsigned CTRL_POR_CLR_BIT = 1;
    localparam int unsigned CTRL_FAULT_CLR_BIT = 2;
    // status word fields
    localparam int unsigned STAT_HIST_BIT = 0;
    localparam int unsigned STAT_LOWSUP_BIT = 1;
    localparam int unsigned STAT_MODE_LSB = 2;
    localparam int unsigned STAT_BELOW_BIT = 4;
    localparam int unsigned STAT_ERRPIN_BIT = 5;
    // config word fields
    localparam int unsigned CFG_MULT_LSB = 0;
    localparam int unsigned CFG_THR_LSB = 4;
    // reset values of registers without a stored copy
    localparam logic [11:0] DUTY_RESET = 12'hfff;
    // full-scale multiplier per select code
    localparam logic [9:0] K_SEL_00 = 10'h040;
    localparam logic [9:0] K_SEL_01 = 10'h080;
    localparam logic [9:0] K_SEL_10 = 10'h100;
    localparam logic [9:0] K_SEL_11 = 10'h200;
    // low-supply threshold in supply conversion codes: code n -> base + (n-1)*step
    localparam logic [7:0] LOW_SUP_BASE = 8'h40;
    localparam logic [7:0] LOW_SUP_STEP = 8'h0c;
    // host silence before fail-safe, and clock rate
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned WDT_TIME_US = 1000;
    localparam int unsigned WDT_CYCLES_DEF = WDT_TIME_US * CLK_MHZ;
    // device operating modes
    typedef enum logic [1:0] {ST_POR, ST_INIT, ST_NORMAL, ST_FAILSAFE} mode_e;
endpackage : led_startup_pkg

// ===== design/led_startup.sv
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module led_startup #(
    parameter int unsigned WDT_CYCLES = led_startup_pkg::WDT_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic supply_ok,
    input wire logic regulator_ok,
    input wire logic [7:0] supply_code,
    input wire logic supply_code_valid,
    input wire logic [15:0] nv_init_wait_length,
    input wire logic [71:0] nv_channel_current_step,
    input wire logic [11:0] nv_failsafe_on,
    input wire logic [1:0] nv_full_scale_multiplier_sel,
    input wire logic [3:0] nv_low_supply_threshold,
    input wire logic err_i,
    output logic err_o,
    output logic err_oe,
    output logic [11:0] ch_out,
    output logic [71:0] channel_current_step,
    output logic [9:0] full_scale_multiplier,
    output logic low_supply_warning,
    output logic open_detect_en,
    output logic short_detect_en,
    output logic poweron_history
);
    localparam int unsigned NCH = led_startup_pkg::NCH;

    // pin synchronisers, first stage read only by second
    logic supply_ok_s1_q, supply_ok_s2_q;
    logic regulator_ok_s1_q, regulator_ok_s2_q;
    logic err_s1_q, err_s2_q;

    led_startup_pkg::mode_e mode_q;
    logic por_now; // either supply under its threshold
    logic [15:0] init_cnt_q; // init wait countdown
    logic [15:0] wdt_q; // host silence counter
    logic [11:0] pwm_cnt_q; // shared pwm time base
    logic [11:0] pwm_on; // per-channel pwm phase
    logic [11:0] channel_output_enable_q;
    logic [11:0] failsafe_on_q;
    logic [1:0] full_scale_multiplier_sel_q;
    logic [3:0] low_supply_threshold_q;
    logic [143:0] duty_q; // twelve-bit duty per channel
    logic below_q; // last conversion was under threshold
    logic [7:0] thr_code; // threshold in conversion units
    logic below_now;

    // apb decode
    logic wr_en, rd_cycle, hit, step_hit, duty_hit;
    logic [3:0] idx;
    logic [31:0] rd_data;
    logic reload_cmd, por_clr_cmd, fault_clr_cmd;
    logic load_nv;

    // bring the analog comparator levels and the fault pin into pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_ok_s1_q <= 1'b0;
            supply_ok_s2_q <= 1'b0;
            regulator_ok_s1_q <= 1'b0;
            regulator_ok_s2_q <= 1'b0;
            err_s1_q <= 1'b1;
            err_s2_q <= 1'b1;
        end else begin
            supply_ok_s1_q <= supply_ok;
            supply_ok_s2_q <= supply_ok_s1_q;
            regulator_ok_s1_q <= regulator_ok;
            regulator_ok_s2_q <= regulator_ok_s1_q;
            err_s1_q <= err_i;
            err_s2_q <= err_s1_q;
        end
    end

    assign por_now = !(supply_ok_s2_q && regulator_ok_s2_q);

    // bus access: one wait state, write lands on the ready edge
    assign step_hit = (paddr[11:6] == led_startup_pkg::ADDR_STEP_BASE[11:6]) && (idx < 4'hc);
    assign duty_hit = (paddr[11:6] == led_startup_pkg::ADDR_DUTY_BASE[11:6]) && (idx < 4'hc);
    assign idx = paddr[5:2];
    assign hit = step_hit || duty_hit || (paddr == led_startup_pkg::ADDR_CTRL)
        || (paddr == led_startup_pkg::ADDR_STATUS) || (paddr == led_startup_pkg::ADDR_CONFIG)
        || (paddr == led_startup_pkg::ADDR_ENABLE) || (paddr == led_startup_pkg::ADDR_FAILSAFE);
    assign rd_cycle = psel && penable && !pready;
    assign wr_en = psel && penable && pready && pwrite && hit;
    assign reload_cmd = wr_en && (paddr == led_startup_pkg::ADDR_CTRL)
        && pwdata[led_startup_pkg::CTRL_RELOAD_BIT];
    assign por_clr_cmd = wr_en && (paddr == led_startup_pkg::ADDR_CTRL)
        && pwdata[led_startup_pkg::CTRL_POR_CLR_BIT];
    assign fault_clr_cmd = wr_en && (paddr == led_startup_pkg::ADDR_CTRL)
        && pwdata[led_startup_pkg::CTRL_FAULT_CLR_BIT];
    // stored copies are taken while held in reset and on reload
    assign load_nv = (mode_q == led_startup_pkg::ST_POR) || reload_cmd;

    // read mux; command bits always read back zero
    always_comb begin
        rd_data = 32'h0;
        if (step_hit) begin
            rd_data[5:0] = channel_current_step[idx * 6 +: 6];
        end else if (duty_hit) begin
            rd_data[11:0] = duty_q[idx * 12 +: 12];
        end else if (paddr == led_startup_pkg::ADDR_STATUS) begin
            rd_data[led_startup_pkg::STAT_HIST_BIT] = poweron_history;
            rd_data[led_startup_pkg::STAT_LOWSUP_BIT] = low_supply_warning;
            rd_data[led_startup_pkg::STAT_MODE_LSB +: 2] = mode_q;
            rd_data[led_startup_pkg::STAT_BELOW_BIT] = below_q;
            rd_data[led_startup_pkg::STAT_ERRPIN_BIT] = err_s2_q;
        end else if (paddr == led_startup_pkg::ADDR_CONFIG) begin
            rd_data[led_startup_pkg::CFG_MULT_LSB +: 2] = full_scale_multiplier_sel_q;
            rd_data[led_startup_pkg::CFG_THR_LSB +: 4] = low_supply_threshold_q;
        end else if (paddr == led_startup_pkg::ADDR_ENABLE) begin
            rd_data[11:0] = channel_output_enable_q;
        end else if (paddr == led_startup_pkg::ADDR_FAILSAFE) begin
            rd_data[11:0] = failsafe_on_q;
        end
    end

    // bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_cycle;
            // unmapped addresses answer with an error and zero data
            if (rd_cycle) begin
                prdata <= pwrite ? 32'h0 : rd_data;
                pslverr <= !hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // operating mode sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= led_startup_pkg::ST_POR;
        end else if (por_now) begin
            mode_q <= led_startup_pkg::ST_POR;
        end else begin
            unique case (mode_q)
                led_startup_pkg::ST_POR: mode_q <= led_startup_pkg::ST_INIT;
                led_startup_pkg::ST_INIT: begin
                    // early exit on flag clear wins over the running timer
                    if (por_clr_cmd || init_cnt_q == 16'h0) begin
                        mode_q <= led_startup_pkg::ST_NORMAL;
                    end
                end
                led_startup_pkg::ST_NORMAL: begin
                    if (wdt_q == 16'(WDT_CYCLES - 1)) begin
                        mode_q <= led_startup_pkg::ST_FAILSAFE;
                    end
                end
                led_startup_pkg::ST_FAILSAFE: begin
                    // any host write to a mapped register shows the link is back
                    if (wr_en) begin
                        mode_q <= led_startup_pkg::ST_NORMAL;
                    end
                end
            endcase
        end
    end

    // init wait countdown, loaded while still in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_q <= 16'h0;
        end else if (mode_q == led_startup_pkg::ST_POR) begin
            init_cnt_q <= nv_init_wait_length;
        end else if (mode_q == led_startup_pkg::ST_INIT && init_cnt_q != 16'h0) begin
            init_cnt_q <= init_cnt_q - 16'h1;
        end
    end

    // host silence watchdog, restarted by every write to a mapped register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_q <= 16'h0;
        end else if (mode_q != led_startup_pkg::ST_NORMAL || wr_en) begin
            wdt_q <= 16'h0;
        end else begin
            wdt_q <= wdt_q + 16'h1;
        end
    end

    // history flag: a setting event beats a simultaneous clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poweron_history <= 1'b1;
        end else if (load_nv) begin
            poweron_history <= 1'b1;
        end else if (por_clr_cmd) begin
            poweron_history <= 1'b0;
        end
    end

    // global configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_scale_multiplier_sel_q <= 2'h3;
            low_supply_threshold_q <= 4'h0;
            failsafe_on_q <= 12'h000;
            channel_output_enable_q <= 12'h000;
        end else if (load_nv) begin
            full_scale_multiplier_sel_q <= nv_full_scale_multiplier_sel;
            low_supply_threshold_q <= nv_low_supply_threshold;
            failsafe_on_q <= nv_failsafe_on;
            channel_output_enable_q <= 12'h000;
        end else if (wr_en) begin
            if (paddr == led_startup_pkg::ADDR_CONFIG) begin
                full_scale_multiplier_sel_q <= pwdata[led_startup_pkg::CFG_MULT_LSB +: 2];
                low_supply_threshold_q <= pwdata[led_startup_pkg::CFG_THR_LSB +: 4];
            end
            if (paddr == led_startup_pkg::ADDR_ENABLE) begin
                channel_output_enable_q <= pwdata[11:0];
            end
            if (paddr == led_startup_pkg::ADDR_FAILSAFE) begin
                failsafe_on_q <= pwdata[11:0];
            end
        end
    end

    // multiplier decode kept registered so the output is glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_scale_multiplier <= led_startup_pkg::K_SEL_11;
        end else begin
            unique case (full_scale_multiplier_sel_q)
                2'h0: full_scale_multiplier <= led_startup_pkg::K_SEL_00;
                2'h1: full_scale_multiplier <= led_startup_pkg::K_SEL_01;
                2'h2: full_scale_multiplier <= led_startup_pkg::K_SEL_10;
                2'h3: full_scale_multiplier <= led_startup_pkg::K_SEL_11;
            endcase
        end
    end

    // low-supply compare; code zero leaves the check off (sixteen codes, fifteen levels)
    assign thr_code = led_startup_pkg::LOW_SUP_BASE
        + 8'(({4'h0, low_supply_threshold_q} - 8'h1) * led_startup_pkg::LOW_SUP_STEP);
    assign below_now = supply_code_valid && (low_supply_threshold_q != 4'h0)
        && (supply_code < thr_code);

    // warning flag: a fresh under-threshold conversion beats a fault clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below_q <= 1'b0;
            low_supply_warning <= 1'b0;
        end else if (mode_q == led_startup_pkg::ST_POR) begin
            below_q <= 1'b0;
            low_supply_warning <= 1'b0;
        end else begin
            if (supply_code_valid) begin
                below_q <= below_now;
            end
            if (below_now) begin
                low_supply_warning <= 1'b1;
            end else if (fault_clr_cmd) begin
                low_supply_warning <= 1'b0;
            end
        end
    end

    // detection gating follows the latest comparison
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_detect_en <= 1'b0;
            short_detect_en <= 1'b0;
        end else begin
            open_detect_en <= !below_q && mode_q != led_startup_pkg::ST_POR;
            short_detect_en <= !below_q && mode_q != led_startup_pkg::ST_POR;
        end
    end

    // fault pin: pulled low only while held in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_oe <= 1'b1;
            err_o <= 1'b0;
        end else begin
            err_oe <= (mode_q == led_startup_pkg::ST_POR);
            err_o <= 1'b0;
        end
    end

    // shared pwm time base; 4096 steps per period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_q <= 12'h000;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 12'h001;
        end
    end

    // per-channel current code, duty and output drive
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                channel_current_step[c * 6 +: 6] <= 6'h00;
                duty_q[c * 12 +: 12] <= led_startup_pkg::DUTY_RESET;
            end else if (load_nv) begin
                channel_current_step[c * 6 +: 6] <= nv_channel_current_step[c * 6 +: 6];
                duty_q[c * 12 +: 12] <= led_startup_pkg::DUTY_RESET;
            end else if (wr_en && idx == 4'(c)) begin
                if (step_hit) begin
                    channel_current_step[c * 6 +: 6] <= pwdata[5:0];
                end
                if (duty_hit) begin
                    duty_q[c * 12 +: 12] <= pwdata[11:0];
                end
            end
        end

        // on for duty+1 of every 4096 steps
        assign pwm_on[c] = (pwm_cnt_q <= duty_q[c * 12 +: 12]);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ch_out[c] <= 1'b0;
            end else begin
                unique case (mode_q)
                    led_startup_pkg::ST_NORMAL:
                        ch_out[c] <= channel_output_enable_q[c] && pwm_on[c];
                    led_startup_pkg::ST_FAILSAFE:
                        ch_out[c] <= failsafe_on_q[c];
                    default: ch_out[c] <= 1'b0;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_clr_in_init;
        mode_q == led_startup_pkg::ST_INIT && por_clr_cmd && !reload_cmd && !por_now;
    endsequence
    sequence s_normal_clear;
        mode_q == led_startup_pkg::ST_NORMAL && !poweron_history;
    endsequence

    property p_por_outputs_off;
        mode_q == led_startup_pkg::ST_POR |=> ch_out == 12'h000 && err_oe;
    endproperty
    a_por_outputs_off: assert property (p_por_outputs_off)
        else $error("outputs not off in reset");

    property p_history_set;
        mode_q == led_startup_pkg::ST_POR |=> poweron_history;
    endproperty
    a_history_set: assert property (p_history_set)
        else $error("history flag not set by reset");

    property p_init_release;
        mode_q == led_startup_pkg::ST_POR && !por_now
            |=> mode_q == led_startup_pkg::ST_INIT ##1 !err_oe;
    endproperty
    a_init_release: assert property (p_init_release)
        else $error("init entry or pin release wrong");

    property p_timer_done;
        mode_q == led_startup_pkg::ST_INIT && init_cnt_q == 16'h0 && !por_now
            |=> mode_q == led_startup_pkg::ST_NORMAL;
    endproperty
    a_timer_done: assert property (p_timer_done)
        else $error("init timer expiry ignored");

    property p_early_exit;
        s_clr_in_init |=> s_normal_clear;
    endproperty
    a_early_exit: assert property (p_early_exit)
        else $error("flag clear did not end init");

    property p_reload;
        reload_cmd && !por_now |=> poweron_history && channel_output_enable_q == 12'h000
            ##2 ch_out == 12'h000;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload did not restore state");

    property p_low_supply;
        below_now && mode_q != led_startup_pkg::ST_POR && !por_now
            |=> low_supply_warning ##1 !open_detect_en && !short_detect_en;
    endproperty
    a_low_supply: assert property (p_low_supply)
        else $error("low supply not flagged or gated");

    property p_mult;
        full_scale_multiplier_sel_q == 2'h0 |=> full_scale_multiplier == 10'h040;
    endproperty
    a_mult: assert property (p_mult)
        else $error("multiplier select decode wrong");

    property p_disabled_off;
        mode_q == led_startup_pkg::ST_NORMAL && !channel_output_enable_q[0] |=> !ch_out[0];
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("disabled channel driven");
endmodule : led_startup

// ===== testbench/host_model.sv
`timescale 1ns/1ps
// host side of the register bus, one transfer at a time
module host_model (
    input wire logic pclk,
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    logic [31:0] rdata; // word taken at the ready edge
    logic rerr; // error flag taken with it
    // bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // setup then access, request held until ready is sampled
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // ready is taken at the rising edge, as the slave itself sees it
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // answer taken at the ready edge, release only after it
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~d;
        if (n >= 20) tb_led_startup.results(1'b1); // hung bus ends the run
    endtask : xfer
endmodule : host_model

// ===== testbench/tb_led_startup.sv
`timescale 1ns/1ps
module tb_led_startup;
    logic pclk = 1'b0, presetn = 1'b0, supply_ok = 1'b0, regulator_ok = 1'b1, code_vld = 1'b0;
    logic [7:0] code = 8'hff; // supply conversion value
    logic [15:0] nv_len = 16'h0100; // long enough to act inside init
    logic [71:0] nv_step = 72'h0123456789abcdef0f, step; // stored current codes
    logic [11:0] fs = 12'ha5c, paddr, ch; // stored fail-safe pattern
    logic [31:0] pwdata, prdata, r;
    logic psel, penable, pwrite, pready, pslverr, err_i, err_o, oe, warn, od, sd, hist;
    logic [9:0] mult; // live full-scale multiplier
    int checks = 0, bad_count = 0;
    assign err_i = oe ? err_o : 1'b1; // pulled-up open-drain fault pin
    always #12.5 pclk = ~pclk;
    host_model host_model_i (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    led_startup #(.WDT_CYCLES(50)) led_startup_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .supply_ok(supply_ok),
        .regulator_ok(regulator_ok), .supply_code(code), .supply_code_valid(code_vld),
        .nv_init_wait_length(nv_len), .nv_channel_current_step(nv_step),
        .nv_failsafe_on(fs), .nv_full_scale_multiplier_sel(2'b01),
        .nv_low_supply_threshold(4'h3), .err_i(err_i), .err_o(err_o), .err_oe(oe),
        .ch_out(ch), .channel_current_step(step), .full_scale_multiplier(mult),
        .low_supply_warning(warn), .open_detect_en(od), .short_detect_en(sd),
        .poweron_history(hist));
    // compare and count
    task automatic chk(input logic [71:0] s, input logic [71:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_model_i.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        host_model_i.xfer(1'b0, a, 32'h0);
        r = host_model_i.rdata;
    endtask : rd
    // one conversion pulse, then let flag and detect settle
    task automatic conv(input logic [7:0] c);
        @(posedge pclk);
        code <= c;
        code_vld <= 1'b1;
        @(posedge pclk);
        code_vld <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : conv
    // single exit point
    task automatic results(input logic hung);
        if (hung) bad_count++;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (2) @(posedge pclk);
        chk(oe, 1'b1);
        chk(ch, 12'h000);
        chk(hist, 1'b1);
        presetn <= 1'b1;
        rd(led_startup_pkg::ADDR_STATUS);
        chk(r & 32'h2c, 32'h0);
        supply_ok <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(led_startup_pkg::ADDR_STATUS);
        chk(r & 32'h2d, 32'h25);
        chk(mult, 10'h080);
        chk(step, nv_step);
        rd(led_startup_pkg::ADDR_CONFIG);
        chk(r, 32'h31);
        wr(led_startup_pkg::ADDR_CTRL, 32'h2);
        rd(led_startup_pkg::ADDR_STATUS);
        chk(r & 32'h2d, 32'h28);
        $display("startup test done");
        for (int s = 0; s < 4; s++) begin
            wr(led_startup_pkg::ADDR_CONFIG, 32'h30 | s);
            repeat (2) @(posedge pclk);
            chk(mult, 10'h040 << s);
        end
        conv(8'h58);
        chk(warn, 1'b0);
        conv(8'h57);
        chk({warn, od, sd}, 3'b100);
        wr(led_startup_pkg::ADDR_CTRL, 32'h4);
        @(posedge pclk);
        chk(warn, 1'b0);
        $display("config test done");
        wr(led_startup_pkg::ADDR_ENABLE, 32'hfff);
        repeat (3) @(posedge pclk);
        chk(ch, 12'hfff);
        wr(led_startup_pkg::ADDR_STEP_BASE + 12'h02c, 32'h15);
        @(posedge pclk);
        chk(step[71:66], 6'h15);
        wr(led_startup_pkg::ADDR_DUTY_BASE + 12'h004, 32'h123);
        rd(led_startup_pkg::ADDR_DUTY_BASE + 12'h004);
        chk(r, 32'h123);
        wr(led_startup_pkg::ADDR_CTRL, 32'h1);
        @(posedge pclk);
        chk(hist, 1'b1);
        chk(step, nv_step);
        rd(led_startup_pkg::ADDR_ENABLE);
        chk(r, 32'h0);
        rd(led_startup_pkg::ADDR_DUTY_BASE + 12'h004);
        chk(r, 32'hfff);
        rd(12'hffc);
        chk({host_model_i.rerr, r}, {1'b1, 32'h0});
        $display("reload test done");
        repeat (60) @(posedge pclk);
        rd(led_startup_pkg::ADDR_STATUS);
        chk(r & 32'h0c, 32'h0c);
        chk(ch, fs);
        supply_ok <= 1'b0;
        nv_len <= 16'h0008;
        repeat (6) @(posedge pclk);
        chk({oe, ch, hist}, {1'b1, 12'h000, 1'b1});
        supply_ok <= 1'b1;
        repeat (20) @(posedge pclk);
        rd(led_startup_pkg::ADDR_STATUS);
        chk(r & 32'h0c, 32'h08);
        $display("power test done");
        results(1'b0);
    end
endmodule : tb_led_startup
